/* design/dgoc_consts.vh */
`ifndef DGOC_CONSTS_VH
`define DGOC_CONSTS_VH
// ****************************************
// Register byte addresses
// ****************************************
`define DGOC_ADDR_W          12
`define DGOC_OFS_CONTROL     12'h000
`define DGOC_OFS_SRCSEL0     12'h004
`define DGOC_OFS_SRCSEL1     12'h008
`define DGOC_OFS_GRPOFS0     12'h00c
`define DGOC_OFS_GRPOFS1     12'h010
`define DGOC_OFS_STATUS      12'h014
`define DGOC_OFS_SRCALL      12'h018
`define DGOC_OFS_DATA        12'h100
`define DGOC_OFS_GAIN        12'h200
`define DGOC_OFS_OFFSET      12'h300
`define DGOC_OFS_WIDTH       12'h04c
// ****************************************
// Field positions
// ****************************************
`define DGOC_CTRL_BANK_BIT   2
`define DGOC_CH_ALL_BIT      6
`define DGOC_CH_GRP_BIT      5
`define DGOC_CH_GSEL_BIT     3
// ****************************************
// Reset values
// ****************************************
`define DGOC_GRPOFS_RESET    14'h2000
`define DGOC_SRCSEL_RESET    8'h00
`endif

/* design/dgoc_datapath.v */
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`include "dgoc_consts.vh"
module dgoc_datapath #(
    parameter NCH  = 16,
    parameter DW   = 16,
    parameter INITC = 64
) (
    // Clock and reset
    input  wire                   clock,
    input  wire                   rst,
    input  wire                   clkEn,
    // Avalon-MM slave
    input  wire [`DGOC_ADDR_W-1:0] avsAddress,
    input  wire                   avsRead,
    input  wire                   avsWrite,
    input  wire [31:0]            avsWriteData,
    output reg  [31:0]            avsReadData,
    output reg                    avsWaitRequest,
    // Pins
    input  wire                   loadOutputsN,
    input  wire                   clearOutputsN,
    input  wire                   suppliesValid,
    // Analog side
    output reg  [NCH*DW-1:0]      dacCode,
    output reg  [NCH*14-1:0]      dacOffsetSub,
    output reg                    signalGroundRef,
    output reg                    busyN
);
    localparam CW = (NCH <= 1) ? 1 : $clog2(NCH);
    localparam [DW-1:0] DMID  = {1'b1, {(DW-1){1'b0}}};
    localparam [DW-1:0] DFULL = {DW{1'b1}};
    localparam S_IDLE = 2'd0;
    localparam S_MUL  = 2'd1;
    localparam S_ADD  = 2'd2;
    localparam S_ACK  = 2'd3;
    // ****************************************
    // Storage
    // ****************************************
    reg [DW-1:0] inA [0:NCH-1];
    reg [DW-1:0] inB [0:NCH-1];
    reg [DW-1:0] gain [0:NCH-1];
    reg [DW-1:0] offs [0:NCH-1];
    reg [DW-1:0] calA [0:NCH-1];
    reg [DW-1:0] calB [0:NCH-1];
    reg [NCH-1:0] dirtyA_q;
    reg [NCH-1:0] dirtyB_q;
    reg [NCH-1:0] pendA_q;
    reg [NCH-1:0] pendB_q;
    reg [7:0]     srcSel0_q;
    reg [7:0]     srcSel1_q;
    reg [13:0]    grpOfs0_q;
    reg [13:0]    grpOfs1_q;
    reg           bank_q;
    reg [1:0]     state_q;
    reg [CW-1:0]  ch_q;
    reg           chB_q;
    reg [2*DW+1:0] prod_q;
    reg           ldPend_q;
    reg [1:0]     ldSync_q;
    reg [1:0]     clrSync_q;
    reg [1:0]     supSync_q;
    reg           ldPrev_q;
    reg           released_q;
    reg [7:0]     initCnt_q;
    reg           initDone_q;
    reg [NCH-1:0] srcVec;
    reg           found;
    reg [CW-1:0]  pickCh;
    reg           pickB;
    reg [NCH-1:0] hitMask;
    reg signed [2*DW+3:0] sum;
    reg [DW-1:0]  clamped;
    integer i;
    wire [`DGOC_ADDR_W-1:0] a = avsAddress;
    // Channel field is the word index inside one 256-byte array
    wire [7:0] chField = {2'b00, a[7:2]};
    wire isArr = (a[11:8] != 4'h0) && (a[11:8] <= 4'h3);
    wire busyNow = (pendA_q != {NCH{1'b0}}) || (pendB_q != {NCH{1'b0}}) || (state_q != S_IDLE);
    wire ldFall = ~ldSync_q[1] & ldPrev_q;
    // Channel selector: single or one group of eight; chField bit 6 (all) is always zero
    always @* begin
        hitMask = {NCH{1'b0}};
        for (i = 0; i < NCH; i = i + 1) begin
            if (chField[`DGOC_CH_ALL_BIT])
                hitMask[i] = 1'b1;
            else if (chField[`DGOC_CH_GRP_BIT])
                hitMask[i] = ((i / 8) == chField[`DGOC_CH_GSEL_BIT]);
            else
                hitMask[i] = (i == chField);
        end
    end
    // Lowest pending channel first, A before B
    always @* begin
        found = 1'b0;
        pickCh = {CW{1'b0}};
        pickB = 1'b0;
        for (i = NCH - 1; i >= 0; i = i - 1) begin
            if (pendA_q[i] | pendB_q[i]) begin
                found = 1'b1;
                pickCh = i[CW-1:0];
                pickB = ~pendA_q[i];
            end
        end
    end
    // Saturating sum at both ends
    always @* begin
        sum = $signed({2'b00, prod_q[2*DW-1:DW]}) + $signed({{(DW+4){1'b0}}, offs[ch_q]})
            - $signed({{(DW+4){1'b0}}, DMID});
        if (sum < 0)
            clamped = {DW{1'b0}};
        else if (sum > $signed({{(DW+4){1'b0}}, DFULL}))
            clamped = DFULL;
        else
            clamped = sum[DW-1:0];
    end
    always @* begin
        for (i = 0; i < NCH; i = i + 1)
            srcVec[i] = (i < 8) ? srcSel0_q[i % 8] : srcSel1_q[i % 8];
    end
    // ****************************************
    // Sequential logic
    // ****************************************
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            for (i = 0; i < NCH; i = i + 1) begin
                inA[i]  <= DMID;
                inB[i]  <= DMID;
                gain[i] <= DFULL;
                offs[i] <= DMID;
                calA[i] <= DMID;
                calB[i] <= DMID;
            end
            dirtyA_q <= {NCH{1'b0}};
            dirtyB_q <= {NCH{1'b0}};
            pendA_q <= {NCH{1'b0}};
            pendB_q <= {NCH{1'b0}};
            srcSel0_q <= `DGOC_SRCSEL_RESET;
            srcSel1_q <= `DGOC_SRCSEL_RESET;
            grpOfs0_q <= `DGOC_GRPOFS_RESET;
            grpOfs1_q <= `DGOC_GRPOFS_RESET;
            bank_q <= 1'b0;
            state_q <= S_IDLE;
            ch_q <= {CW{1'b0}};
            chB_q <= 1'b0;
            prod_q <= {(2*DW+2){1'b0}};
            ldPend_q <= 1'b0;
            ldSync_q <= 2'b11;
            clrSync_q <= 2'b00;
            supSync_q <= 2'b00;
            ldPrev_q <= 1'b1;
            released_q <= 1'b0;
            initCnt_q <= 8'h00;
            initDone_q <= 1'b0;
            avsReadData <= 32'h0;
            avsWaitRequest <= 1'b1;
            dacCode <= {NCH{DMID}};
            dacOffsetSub <= {NCH{14'h0}};
            signalGroundRef <= 1'b1;
            busyN <= 1'b1;
        end else if (clkEn) begin
            ldSync_q <= {ldSync_q[0], loadOutputsN};
            clrSync_q <= {clrSync_q[0], clearOutputsN};
            supSync_q <= {supSync_q[0], suppliesValid};
            ldPrev_q <= ldSync_q[1];
            busyN <= ~busyNow;
            avsWaitRequest <= 1'b1;
            // Shared arithmetic: one multiply, then one add
            case (state_q)
                S_IDLE: begin
                    if (found) begin
                        ch_q <= pickCh;
                        chB_q <= pickB;
                        if (pickB)
                            pendB_q[pickCh] <= 1'b0;
                        else
                            pendA_q[pickCh] <= 1'b0;
                        state_q <= S_MUL;
                    end
                end
                S_MUL: begin
                    prod_q <= (chB_q ? inB[ch_q] : inA[ch_q]) * ({1'b0, gain[ch_q]} + 1'b1);
                    state_q <= S_ADD;
                end
                S_ADD: begin
                    if (chB_q) begin
                        calB[ch_q] <= clamped;
                        dirtyB_q[ch_q] <= 1'b1;
                    end else begin
                        calA[ch_q] <= clamped;
                        dirtyA_q[ch_q] <= 1'b1;
                    end
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
            // Bus slave, one wait cycle per access
            if ((avsRead | avsWrite) & avsWaitRequest & ~(~avsWaitRequest)) begin
                avsWaitRequest <= 1'b0;
                if (avsRead) begin
                    case (a)
                        `DGOC_OFS_CONTROL: avsReadData <= {29'h0, bank_q, 2'b00};
                        `DGOC_OFS_SRCSEL0: avsReadData <= {24'h0, srcSel0_q};
                        `DGOC_OFS_SRCSEL1: avsReadData <= {24'h0, srcSel1_q};
                        `DGOC_OFS_GRPOFS0: avsReadData <= {18'h0, grpOfs0_q};
                        `DGOC_OFS_GRPOFS1: avsReadData <= {18'h0, grpOfs1_q};
                        `DGOC_OFS_STATUS:  avsReadData <= {29'h0, initDone_q, ldPend_q, busyNow};
                        default:           avsReadData <= 32'h0;
                    endcase
                end
            end
            if (avsWrite & ~avsWaitRequest) begin
                case (a)
                    `DGOC_OFS_CONTROL: bank_q <= avsWriteData[`DGOC_CTRL_BANK_BIT];
                    `DGOC_OFS_SRCSEL0: srcSel0_q <= avsWriteData[7:0];
                    `DGOC_OFS_SRCSEL1: srcSel1_q <= avsWriteData[7:0];
                    `DGOC_OFS_GRPOFS0: grpOfs0_q <= avsWriteData[13:0];
                    `DGOC_OFS_GRPOFS1: grpOfs1_q <= avsWriteData[13:0];
                    `DGOC_OFS_SRCALL: begin
                        srcSel0_q <= {8{avsWriteData[0]}};
                        srcSel1_q <= {8{avsWriteData[0]}};
                    end
                    default: ;
                endcase
                if (isArr) begin
                    for (i = 0; i < NCH; i = i + 1) begin
                        if (hitMask[i]) begin
                            if (a[11:8] == 4'h1) begin
                                if (bank_q) begin
                                    inB[i] <= avsWriteData[DW-1:0];
                                    pendB_q[i] <= 1'b1;
                                end else begin
                                    inA[i] <= avsWriteData[DW-1:0];
                                    pendA_q[i] <= 1'b1;
                                end
                            end else begin
                                if (a[11:8] == 4'h2)
                                    gain[i] <= avsWriteData[DW-1:0];
                                else
                                    offs[i] <= avsWriteData[DW-1:0];
                                if (bank_q)
                                    pendB_q[i] <= 1'b1;
                                else
                                    pendA_q[i] <= 1'b1;
                            end
                        end
                    end
                end
            end
            // Power-up hold: supplies valid, then a short init count
            if (supSync_q[1] & ~initDone_q) begin
                if (initCnt_q == INITC[7:0] - 8'h01)
                    initDone_q <= 1'b1;
                else
                    initCnt_q <= initCnt_q + 8'h01;
            end
            // Clear low grounds the outputs; the first release waits for clear high, later ones for the next load
            if (~clrSync_q[1] | ~initDone_q) begin
                signalGroundRef <= 1'b1;
                if (~clrSync_q[1] & released_q)
                    released_q <= 1'b1;
                ldPend_q <= 1'b0;
            end else if (~released_q) begin
                released_q <= 1'b1;
                signalGroundRef <= 1'b0;
                for (i = 0; i < NCH; i = i + 1)
                    dacCode[i*DW +: DW] <= srcVec[i] ? calB[i] : calA[i];
            end else begin
                // Loads seen during busy are held until busy drops
                if (ldFall | (~ldSync_q[1] & ldPend_q) | ldPend_q)
                    ldPend_q <= busyNow;
                if ((ldFall | ldPend_q | ~ldSync_q[1]) & ~busyNow) begin
                    signalGroundRef <= 1'b0;
                    for (i = 0; i < NCH; i = i + 1) begin
                        if (srcVec[i] ? dirtyB_q[i] : dirtyA_q[i])
                            dacCode[i*DW +: DW] <= srcVec[i] ? calB[i] : calA[i];
                    end
                    dirtyA_q <= {NCH{1'b0}};
                    dirtyB_q <= {NCH{1'b0}};
                end else if (ldFall)
                    ldPend_q <= 1'b1;
            end
            // Group offset copied to each channel as 14 bits: channels 0-7 from grpOfs0_q, the rest from grpOfs1_q
            for (i = 0; i < NCH; i = i + 1)
                dacOffsetSub[i*14 +: 14] <= (i < 8) ? grpOfs0_q : grpOfs1_q;
        end
    end
endmodule

/* tb/dgoc_pin_host.sv */
`timescale 1ns/100ps
// ****************************************
// Host side pins
// ****************************************
module dgoc_pin_host #(
    parameter LOWC = 2
) (
    // Clock
    input  wire  clock,
    // Bench requests
    input  wire  loadReq,
    input  wire  clearReq,
    input  wire  powerReq,
    // Pins toward the block
    output logic loadOutputsN,
    output logic clearOutputsN,
    output logic suppliesValid
);
    int cnt = 0;
    initial begin
        loadOutputsN = 1'b1;
        clearOutputsN = 1'b1;
        suppliesValid = 1'b0;
    end
    // Strobe kept low for LOWC (2) cycles, as long as the two-flop sync, so it is never lost
    always @(posedge clock) begin
        cnt <= loadReq ? LOWC : (cnt != 0 ? cnt - 1 : 0);
        loadOutputsN <= !(loadReq || cnt > 1);
        clearOutputsN <= !clearReq;
        suppliesValid <= powerReq;
    end
endmodule

/* tb/dgoc_datapath_sva.sv */
`timescale 1ns/100ps
`include "dgoc_consts.vh"
module dgoc_chk #(
    parameter NCH   = 16,
    parameter DW    = 16,
    parameter INITC = 64
) (
    // Clock and reset
    input wire                    clock,
    input wire                    rst,
    // Bus
    input wire [`DGOC_ADDR_W-1:0] avsAddress,
    input wire                    avsRead,
    input wire                    avsWrite,
    input wire [31:0]             avsReadData,
    input wire                    avsWaitRequest,
    // Pins and outputs
    input wire                    loadOutputsN,
    input wire                    clearOutputsN,
    input wire                    suppliesValid,
    input wire [NCH*DW-1:0]       dacCode,
    input wire                    signalGroundRef,
    input wire                    busyN
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ****************************************
    // Checks
    // ****************************************
    ack_next_a: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
        else $error("request not answered next cycle");
    ack_once_a: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("answer stood longer than one cycle");
    unmapped_zero_a: assert property (avsRead && !avsWaitRequest && avsAddress[11:10] != 2'b00 |-> avsReadData == 32'h0)
        else $error("unmapped read not zero");
    clear_ground_a: assert property (!clearOutputsN [*4] |-> signalGroundRef)
        else $error("outputs not grounded while clear low");
    supply_ground_a: assert property (signalGroundRef && !suppliesValid |=> signalGroundRef)
        else $error("ground released without supplies");
    init_hold_a: assert property (signalGroundRef && $rose(suppliesValid) |-> signalGroundRef [*4])
        else $error("ground released before init done");
    clear_freeze_a: assert property (!clearOutputsN [*5] |-> $stable(dacCode))
        else $error("output code moved while clear low");
    busy_gate_a: assert property (!$stable(dacCode) |-> busyN)
        else $error("output code moved while busy");
    write_busy_a: assert property (avsWrite && !avsWaitRequest && avsAddress[11:8] == 4'h1 |-> ##[0:4] !busyN)
        else $error("data write started no recalculation");
    cover property (!$stable(dacCode));
    cover property (!loadOutputsN && !busyN);
    cover property ($fell(signalGroundRef));
endmodule
bind dgoc_datapath dgoc_chk #(.NCH(NCH), .DW(DW), .INITC(INITC)) chk (
    .clock(clock), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .loadOutputsN(loadOutputsN),
    .clearOutputsN(clearOutputsN), .suppliesValid(suppliesValid), .dacCode(dacCode),
    .signalGroundRef(signalGroundRef), .busyN(busyN));

/* tb/test_dac_gain_offset_calib_datapath.sv */
`timescale 1ns/100ps
`include "dgoc_consts.vh"
module test_dac_gain_offset_calib_datapath;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] avsAddress = 12'h000;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    wire  [31:0] avsReadData;
    wire         avsWaitRequest, loadOutputsN, clearOutputsN, suppliesValid, signalGroundRef, busyN;
    wire  [255:0] dacCode;
    logic        loadReq = 1'b0;
    logic        clearReq = 1'b0;
    logic        powerReq = 1'b0;
    logic [31:0] rdData;
    int          errCount = 0;
    int          comparisons = 0;
    initial begin
        forever #2 clock = ~clock;
    end
    dgoc_pin_host host (.clock(clock), .loadReq(loadReq), .clearReq(clearReq), .powerReq(powerReq),
        .loadOutputsN(loadOutputsN), .clearOutputsN(clearOutputsN), .suppliesValid(suppliesValid));
    // Short init count keeps the power-up wait brief
    dgoc_datapath #(.NCH(16), .DW(16), .INITC(4)) dut (.clock(clock), .rst(rst), .clkEn(1'b1),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .loadOutputsN(loadOutputsN),
        .clearOutputsN(clearOutputsN), .suppliesValid(suppliesValid), .dacCode(dacCode),
        .dacOffsetSub(), .signalGroundRef(signalGroundRef), .busyN(busyN));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic endOfTest;
        $display("Comparisons %0d, mismatches %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            errCount++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        n = 0;
        @(posedge clock);
        while (avsWaitRequest !== 1'b0 && n < 50) begin
            @(posedge clock);
            n++;
        end
        rdData = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        if (n == 50) begin
            chk("bus answer", 32'h1, 32'h0);
            endOfTest;
        end
        @(posedge clock);
    endtask
    task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rdData);
    endtask
    task automatic pulse;
        loadReq <= 1'b1;
        @(posedge clock);
        loadReq <= 1'b0;
        @(posedge clock);
    endtask
    task automatic waitCode(input int ch, input logic [15:0] e);
        int n;
        n = 0;
        while (dacCode[ch*16 +: 16] !== e && n < 200) begin
            @(posedge clock);
            n++;
        end
        chk("dac code", {16'h0, e}, {16'h0, dacCode[ch*16 +: 16]});
        if (n == 200) endOfTest;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (20000) @(posedge clock);
        errCount++;
        endOfTest;
    end
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        repeat (10) @(posedge clock);
        chk("ground", 32'h1, {31'h0, signalGroundRef});
        rdChk("grpofs0", `DGOC_OFS_GRPOFS0, 32'h2000);
        rdChk("grpofs1", `DGOC_OFS_GRPOFS1, 32'h2000);
        rdChk("srcsel0", `DGOC_OFS_SRCSEL0, 32'h0);
        rdChk("unmapped", 12'h400, 32'h0);
        chk("midscale", 32'h8000, {16'h0, dacCode[15:0]});
        powerReq <= 1'b1;
        repeat (40) @(posedge clock);
        chk("ground", 32'h0, {31'h0, signalGroundRef});
        $display("power-up test done");
        bus(1'b1, `DGOC_OFS_CONTROL, 32'h0);
        bus(1'b1, 12'h100, 32'h1234);
        pulse;
        waitCode(0, 16'h1234);
        bus(1'b1, `DGOC_OFS_GRPOFS0, 32'h1000);
        rdChk("grpofs0", `DGOC_OFS_GRPOFS0, 32'h1000);
        $display("bank A test done");
        bus(1'b1, `DGOC_OFS_CONTROL, 32'h4);
        bus(1'b1, 12'h104, 32'h5555);
        bus(1'b1, `DGOC_OFS_SRCSEL0, 32'h2);
        rdChk("srcsel0", `DGOC_OFS_SRCSEL0, 32'h2);
        pulse;
        waitCode(1, 16'h5555);
        chk("code0", 32'h1234, {16'h0, dacCode[15:0]});
        bus(1'b1, 12'h204, 32'h7fff);
        pulse;
        waitCode(1, 16'h2aaa);
        bus(1'b1, 12'h304, 32'h8010);
        pulse;
        waitCode(1, 16'h2aba);
        $display("bank B test done");
        bus(1'b1, `DGOC_OFS_SRCALL, 32'h1);
        rdChk("srcsel0", `DGOC_OFS_SRCSEL0, 32'hff);
        rdChk("srcsel1", `DGOC_OFS_SRCSEL1, 32'hff);
        bus(1'b1, `DGOC_OFS_SRCALL, 32'h0);
        rdChk("srcsel1", `DGOC_OFS_SRCSEL1, 32'h0);
        $display("select-all test done");
        bus(1'b1, `DGOC_OFS_CONTROL, 32'h0);
        bus(1'b1, 12'h108, 32'h0111);
        bus(1'b1, 12'h10c, 32'h0222);
        pulse;
        waitCode(2, 16'h0111);
        waitCode(3, 16'h0222);
        $display("load-while-busy test done");
        clearReq <= 1'b1;
        repeat (8) @(posedge clock);
        chk("ground", 32'h1, {31'h0, signalGroundRef});
        bus(1'b1, 12'h100, 32'h4321);
        pulse;
        repeat (20) @(posedge clock);
        chk("code0", 32'h1234, {16'h0, dacCode[15:0]});
        clearReq <= 1'b0;
        $display("clear test done");
        endOfTest;
    end
endmodule
